// ===== hdl/sewc_map.svh
// Register offsets, field positions and reset values of the sleep entry and wake control block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef SEWC_MAP_SVH
`define SEWC_MAP_SVH
// Word byte addresses on the register bus
`define SEWC_OFS_IRQ_CONTROL 6'h00
`define SEWC_OFS_PERIPHERAL_IRQ_ENABLE_1 6'h04
`define SEWC_OFS_PERIPHERAL_IRQ_ENABLE_2 6'h08
`define SEWC_OFS_PERIPHERAL_IRQ_ENABLE_3 6'h0c
`define SEWC_OFS_PERIPHERAL_IRQ_ENABLE_4 6'h10
`define SEWC_OFS_PERIPHERAL_IRQ_FLAGS_1 6'h14
`define SEWC_OFS_PERIPHERAL_IRQ_FLAGS_2 6'h18
`define SEWC_OFS_PERIPHERAL_IRQ_FLAGS_3 6'h1c
`define SEWC_OFS_PERIPHERAL_IRQ_FLAGS_4 6'h20
`define SEWC_OFS_CORE_STATUS 6'h24
`define SEWC_OFS_WAKE_CONFIG 6'h28
`define SEWC_OFS_EVT_STATUS 6'h2c
`define SEWC_OFS_EVT_MASK 6'h30
// Field positions
`define SEWC_GIE_BIT 7
`define SEWC_PERIPHERAL_IRQ_ENABLE_BIT 6
`define SEWC_CAPTURE3_IE_BIT 4
`define SEWC_PD_BIT 3
`define SEWC_TO_BIT 4
// Implemented bit masks
`define SEWC_PERIPHERAL_IRQ_ENABLE_3_MASK 8'h10
`define SEWC_PERIPHERAL_IRQ_ENABLE_4_MASK 8'h77
`define SEWC_IRQ_CONTROL_MASK 8'hf8
// Reset values
`define SEWC_PERIPHERAL_IRQ_ENABLE_3_RESET 8'h00
`define SEWC_STATUS_RESET 8'h18
// Wake configuration fields
`define SEWC_CFG_WDT_SLEEP_BIT 0
`define SEWC_CFG_MASTER_CLEAR_PIN_EN_BIT 1
`define SEWC_CFG_BOR_EN_BIT 2
`define SEWC_CFG_WDT_EN_BIT 3
`define SEWC_CFG_T1SRC_LSB 4
`define SEWC_CFG_ADC_RC_BIT 6
// Secondary timer sources that survive power-down
`define SEWC_T1SRC_LFOSC 2'h1
`define SEWC_T1SRC_PIN 2'h2
`define SEWC_T1SRC_XTAL 2'h3
// Event bits
`define SEWC_EVT_ENTRY 0
`define SEWC_EVT_WAKE_IRQ 1
`define SEWC_EVT_WAKE_WDT 2
`endif

// ===== hdl/sewc_pkg.sv
// Types shared by the sleep entry and wake control block.
// Assumes the map header is on the include path.
`include "sewc_map.svh"
package sewc_pkg;
  typedef struct packed {
    logic [5:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } sewc_bus_req_type;
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } sewc_bus_rsp_type;
  typedef enum logic [1:0] {SEWC_RUN, SEWC_SLEEP, SEWC_WAKE} sewc_state_type;
endpackage : sewc_pkg

// ===== hdl/sewc_top.sv
// Sleep entry and wake control: halt handling, clock gating, pin hold, wake and vectoring.
// Assumes a core on clk giving a one-cycle halt pulse, and asynchronous wake and reset pins.
//
// How it works
// - Sleep is entered only on core halt.
// - Entry clears watchdog; keeps counting if enabled.
// - Entry clears the power-down flag.
// - Entry sets the watchdog expiry flag.
// - Core clock is gated while asleep.
// - Low-frequency oscillator keeps running asleep.
// - Secondary timer runs from qualified sources.
// - ADC runs on on dedicated oscillator.
// - Pins hold their pre-halt drive state.
// - Non-watchdog resets act same asleep.
// - Six wake events end power-down.
// - Reset wakes reset; others continue execution.
// - Next instruction is prefetched during halt.
// - Wake needs own enable, ignores global.
// - Global clear: continue after halt.
// - Global set: execute next, then vector.
// - Watchdog cleared on every wake.
// - Capture3 enable at bit 4, rest zero.
`include "sewc_map.svh"
`timescale 1ns/1ns
`default_nettype none
module sewc_top (
  input wire logic clk, // System clock, 100 MHz
  input wire logic arst_n, // Power-on reset, active low
  input wire sewc_pkg::sewc_bus_req_type bus_req, // Avalon-MM request
  output sewc_pkg::sewc_bus_rsp_type bus_rsp, // Avalon-MM answer
  output logic irq, // Level interrupt
  input wire logic halt_exec, // Core executes halt, one-cycle pulse
  input wire logic instr_retired, // Core completed one instruction
  output logic core_clk_en, // Core clock gate enable
  output logic prefetch_req, // Fetch at program counter plus one
  output logic vector_req, // Call the interrupt service routine
  output logic device_reset_n, // Device reset, active low
  input wire logic master_clear_pin_n, // Master clear pin, active low
  input wire logic brownout_det, // Brown-out detected
  input wire logic watchdog_tick, // Watchdog time base tick
  input wire logic [2:0] ext_irq_pin, // External interrupt pins
  input wire logic [7:0] periph_evt_1, // Peripheral events, group 1
  input wire logic [7:0] periph_evt_2, // Peripheral events, group 2
  input wire logic [7:0] periph_evt_3, // Peripheral events, group 3
  input wire logic [7:0] periph_evt_4, // Peripheral events, group 4
  output logic lf_osc_en, // Low-frequency oscillator enable
  output logic timer2nd_clk_en, // Secondary timer clock enable
  output logic adc_clk_en, // ADC clock enable
  input wire logic [7:0] pin_out_core, // Pin levels from the core
  input wire logic [7:0] pin_oe_core, // Pin enables from the core
  output logic [7:0] pin_out, // Pin levels
  output logic [7:0] pin_oe, // Pin output enables
  output logic [7:0] watchdog_counter // Watchdog count
);
  import sewc_pkg::*;

  // ==========================================================
  // Input synchronisers
  logic [1:0] master_clear_pin_sync;
  logic [1:0] bor_sync;
  logic [1:0] wdt_sync;
  logic [2:0] ext_s1;
  logic [2:0] ext_s2;
  logic [31:0] per_s1;
  logic [31:0] per_s2;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      master_clear_pin_sync <= 2'h3;
      bor_sync <= 2'h0;
      wdt_sync <= 2'h0;
      ext_s1 <= 3'h0;
      ext_s2 <= 3'h0;
      per_s1 <= 32'h0;
      per_s2 <= 32'h0;
    end else begin
      master_clear_pin_sync <= {master_clear_pin_sync[0], master_clear_pin_n};
      bor_sync <= {bor_sync[0], brownout_det};
      wdt_sync <= {wdt_sync[0], watchdog_tick};
      ext_s1 <= ext_irq_pin;
      ext_s2 <= ext_s1;
      per_s1 <= {periph_evt_4, periph_evt_3, periph_evt_2, periph_evt_1};
      per_s2 <= per_s1;
    end
  end

  // ==========================================================
  // Registers
  sewc_state_type state;
  sewc_state_type next_state;
  logic [7:0] irq_control;
  logic [7:0] peripheral_irq_enable_1;
  logic [7:0] peripheral_irq_enable_2;
  logic [7:0] peripheral_irq_enable_3;
  logic [7:0] peripheral_irq_enable_4;
  logic [7:0] peripheral_irq_flags_1;
  logic [7:0] peripheral_irq_flags_2;
  logic [7:0] peripheral_irq_flags_3;
  logic [7:0] peripheral_irq_flags_4;
  logic [7:0] core_status;
  logic [7:0] wake_config;
  logic [2:0] evt_status;
  logic [2:0] evt_mask;
  logic [2:0] ext_prev;
  logic wr;
  logic [7:0] wd;
  logic [2:0] ext_rise;
  logic soft_reset;
  logic wdt_expire;
  logic irq_wake;
  logic wake_any;
  logic entry;
  logic t1_ok;
  logic pend_vector;

  assign wr = bus_req.write;
  assign wd = bus_req.writedata[7:0];
  assign ext_rise = ext_s2 & ~ext_prev;
  // A software reset source: master clear if enabled, or brown-out if enabled
  assign soft_reset = (wake_config[`SEWC_CFG_MASTER_CLEAR_PIN_EN_BIT] & ~master_clear_pin_sync[1])
    | (wake_config[`SEWC_CFG_BOR_EN_BIT] & bor_sync[1]);
  assign wdt_expire = wake_config[`SEWC_CFG_WDT_EN_BIT] & (watchdog_counter == 8'hff) & wdt_sync[1];
  // Own enable only, global enable deliberately ignored
  assign irq_wake = |(irq_control[2:0] & {ext_rise[2], ext_rise[1], ext_rise[0]})
    | |(peripheral_irq_enable_1 & peripheral_irq_flags_1) | |(peripheral_irq_enable_2 & peripheral_irq_flags_2) | |(peripheral_irq_enable_3 & peripheral_irq_flags_3) | |(peripheral_irq_enable_4 & peripheral_irq_flags_4);
  assign wake_any = irq_wake | wdt_expire;
  assign entry = (state == SEWC_RUN) & halt_exec;
  assign t1_ok = (wake_config[5:4] == `SEWC_T1SRC_LFOSC) | (wake_config[5:4] == `SEWC_T1SRC_PIN)
    | (wake_config[5:4] == `SEWC_T1SRC_XTAL);

  // ==========================================================
  // Sleep state machine
  always_comb begin
    next_state = state;
    case (state)
      SEWC_RUN: begin
        if (halt_exec) begin
          next_state = SEWC_SLEEP;
        end
      end
      SEWC_SLEEP: begin
        if (wake_any) begin
          next_state = SEWC_WAKE;
        end
      end
      SEWC_WAKE: begin
        next_state = SEWC_RUN;
      end
      default: begin
        next_state = SEWC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= SEWC_RUN;
    end else if (soft_reset) begin
      state <= SEWC_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Reset wakes restart the device rather than continue
  assign device_reset_n = ~soft_reset;
  assign core_clk_en = (state != SEWC_SLEEP);
  assign lf_osc_en = 1'b1;
  assign timer2nd_clk_en = (state != SEWC_SLEEP) | t1_ok;
  assign adc_clk_en = (state != SEWC_SLEEP) | wake_config[`SEWC_CFG_ADC_RC_BIT];
  assign prefetch_req = entry;

  // ==========================================================
  // Pin hold: the core's pins are frozen while asleep
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
    end else if (state == SEWC_RUN && !halt_exec) begin
      pin_out <= pin_out_core;
      pin_oe <= pin_oe_core;
    end
  end

  // ==========================================================
  // Vectoring after an interrupt wake
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_vector <= 1'b0;
      vector_req <= 1'b0;
    end else begin
      vector_req <= 1'b0;
      if (soft_reset) begin
        pend_vector <= 1'b0;
      end else if (state == SEWC_SLEEP && irq_wake && irq_control[`SEWC_GIE_BIT]) begin
        pend_vector <= 1'b1;
      end else if (pend_vector && state == SEWC_RUN && instr_retired) begin
        pend_vector <= 1'b0;
        vector_req <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Watchdog counter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      watchdog_counter <= 8'h00;
    end else if (entry || state == SEWC_WAKE || soft_reset) begin
      watchdog_counter <= 8'h00;
    end else if (wdt_sync[1] && wake_config[`SEWC_CFG_WDT_EN_BIT]
                 && (state == SEWC_RUN || wake_config[`SEWC_CFG_WDT_SLEEP_BIT])) begin
      watchdog_counter <= watchdog_counter + 8'h01;
    end
  end

  // ==========================================================
  // Core status and configuration
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      core_status <= `SEWC_STATUS_RESET;
      wake_config <= 8'h00;
      irq_control <= 8'h00;
      peripheral_irq_enable_1 <= 8'h00;
      peripheral_irq_enable_2 <= 8'h00;
      peripheral_irq_enable_3 <= `SEWC_PERIPHERAL_IRQ_ENABLE_3_RESET;
      peripheral_irq_enable_4 <= 8'h00;
      evt_mask <= 3'h0;
      ext_prev <= 3'h0;
    end else begin
      ext_prev <= ext_s2;
      if (entry) begin
        core_status[`SEWC_PD_BIT] <= 1'b0;
        core_status[`SEWC_TO_BIT] <= 1'b1;
      end else if (wr && bus_req.address == `SEWC_OFS_CORE_STATUS) begin
        core_status <= wd;
      end
      if (wr) begin
        case (bus_req.address)
          `SEWC_OFS_WAKE_CONFIG: wake_config <= wd;
          `SEWC_OFS_IRQ_CONTROL: irq_control <= wd & `SEWC_IRQ_CONTROL_MASK | wd & 8'h07;
          `SEWC_OFS_PERIPHERAL_IRQ_ENABLE_1: peripheral_irq_enable_1 <= wd;
          `SEWC_OFS_PERIPHERAL_IRQ_ENABLE_2: peripheral_irq_enable_2 <= wd;
          `SEWC_OFS_PERIPHERAL_IRQ_ENABLE_3: peripheral_irq_enable_3 <= wd & `SEWC_PERIPHERAL_IRQ_ENABLE_3_MASK;
          `SEWC_OFS_PERIPHERAL_IRQ_ENABLE_4: peripheral_irq_enable_4 <= wd & `SEWC_PERIPHERAL_IRQ_ENABLE_4_MASK;
          `SEWC_OFS_EVT_MASK: evt_mask <= wd[2:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Peripheral flags: a new event wins over a clearing write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      peripheral_irq_flags_1 <= 8'h00;
      peripheral_irq_flags_2 <= 8'h00;
      peripheral_irq_flags_3 <= 8'h00;
      peripheral_irq_flags_4 <= 8'h00;
    end else begin
      peripheral_irq_flags_1 <= ((wr && bus_req.address == `SEWC_OFS_PERIPHERAL_IRQ_FLAGS_1) ? wd : peripheral_irq_flags_1) | per_s2[7:0];
      peripheral_irq_flags_2 <= ((wr && bus_req.address == `SEWC_OFS_PERIPHERAL_IRQ_FLAGS_2) ? wd : peripheral_irq_flags_2) | per_s2[15:8];
      peripheral_irq_flags_3 <= (((wr && bus_req.address == `SEWC_OFS_PERIPHERAL_IRQ_FLAGS_3) ? wd : peripheral_irq_flags_3) | per_s2[23:16])
        & `SEWC_PERIPHERAL_IRQ_ENABLE_3_MASK;
      peripheral_irq_flags_4 <= (((wr && bus_req.address == `SEWC_OFS_PERIPHERAL_IRQ_FLAGS_4) ? wd : peripheral_irq_flags_4) | per_s2[31:24])
        & `SEWC_PERIPHERAL_IRQ_ENABLE_4_MASK;
    end
  end

  // ==========================================================
  // Block events: write one to clear, set wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      evt_status <= 3'h0;
    end else begin
      evt_status <= (evt_status & ~((wr && bus_req.address == `SEWC_OFS_EVT_STATUS) ? wd[2:0] : 3'h0))
        | {state == SEWC_SLEEP && wdt_expire, state == SEWC_SLEEP && irq_wake, entry};
    end
  end
  assign irq = |(evt_status & evt_mask);

  // ==========================================================
  // Bus answer: zero wait states, read data decoded combinationally from the request
  logic [7:0] rd;
  always_comb begin
    rd = 8'h00;
    case (bus_req.address)
      `SEWC_OFS_IRQ_CONTROL: rd = irq_control;
      `SEWC_OFS_PERIPHERAL_IRQ_ENABLE_1: rd = peripheral_irq_enable_1;
      `SEWC_OFS_PERIPHERAL_IRQ_ENABLE_2: rd = peripheral_irq_enable_2;
      `SEWC_OFS_PERIPHERAL_IRQ_ENABLE_3: rd = peripheral_irq_enable_3;
      `SEWC_OFS_PERIPHERAL_IRQ_ENABLE_4: rd = peripheral_irq_enable_4;
      `SEWC_OFS_PERIPHERAL_IRQ_FLAGS_1: rd = peripheral_irq_flags_1;
      `SEWC_OFS_PERIPHERAL_IRQ_FLAGS_2: rd = peripheral_irq_flags_2;
      `SEWC_OFS_PERIPHERAL_IRQ_FLAGS_3: rd = peripheral_irq_flags_3;
      `SEWC_OFS_PERIPHERAL_IRQ_FLAGS_4: rd = peripheral_irq_flags_4;
      `SEWC_OFS_CORE_STATUS: rd = core_status;
      `SEWC_OFS_WAKE_CONFIG: rd = wake_config;
      `SEWC_OFS_EVT_STATUS: rd = {5'h00, evt_status};
      `SEWC_OFS_EVT_MASK: rd = {5'h00, evt_mask};
      default: rd = 8'h00;
    endcase
  end
  assign bus_rsp.readdata = {24'h000000, rd};
  assign bus_rsp.waitrequest = 1'b0;

  // ==========================================================
  // Checks
  property p_entry_clk;
    @(posedge clk) disable iff (!arst_n) entry && !soft_reset |=> !core_clk_en;
  endproperty
  a_entry_clk: assert property (p_entry_clk) else $error("core clock not gated after halt");
  property p_pd;
    @(posedge clk) disable iff (!arst_n) entry |=> !core_status[`SEWC_PD_BIT];
  endproperty
  a_pd: assert property (p_pd) else $error("power-down flag not cleared");
  property p_to;
    @(posedge clk) disable iff (!arst_n) entry |=> core_status[`SEWC_TO_BIT];
  endproperty
  a_to: assert property (p_to) else $error("expiry flag not set");
  property p_wdt_clr;
    @(posedge clk) disable iff (!arst_n) (entry || state == SEWC_WAKE) |=> watchdog_counter == 8'h00;
  endproperty
  a_wdt_clr: assert property (p_wdt_clr) else $error("watchdog not cleared");
  property p_sleep_only_halt;
    @(posedge clk) disable iff (!arst_n) $rose(state == SEWC_SLEEP) |-> $past(halt_exec);
  endproperty
  a_sleep_only_halt: assert property (p_sleep_only_halt) else $error("sleep without halt");
  property p_pin_hold;
    @(posedge clk) disable iff (!arst_n) state == SEWC_SLEEP ##1 state == SEWC_SLEEP |-> $stable(pin_out)
      && $stable(pin_oe);
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pins moved asleep");
  property p_wake;
    @(posedge clk) disable iff (!arst_n) state == SEWC_SLEEP && irq_wake && !soft_reset |=> state == SEWC_WAKE
      ##1 core_clk_en;
  endproperty
  a_wake: assert property (p_wake) else $error("interrupt did not wake");
  property p_peripheral_irq_enable_3;
    @(posedge clk) disable iff (!arst_n) (peripheral_irq_enable_3 & ~`SEWC_PERIPHERAL_IRQ_ENABLE_3_MASK) == 8'h00;
  endproperty
  a_peripheral_irq_enable_3: assert property (p_peripheral_irq_enable_3) else $error("unused capture enable bits set");
  property p_reset;
    @(posedge clk) disable iff (!arst_n) soft_reset |=> state == SEWC_RUN;
  endproperty
  a_reset: assert property (p_reset) else $error("reset wake did not restart");
  c_sleep: cover property (@(posedge clk) disable iff (!arst_n) entry ##[1:20] state == SEWC_WAKE);
  c_vector: cover property (@(posedge clk) disable iff (!arst_n) vector_req);
  c_reset_wake: cover property (@(posedge clk) disable iff (!arst_n) state == SEWC_SLEEP && soft_reset);
endmodule : sewc_top
`default_nettype wire

// ===== bench/sewc_core_model.sv
// Processor core stand-in: executes halt on command, retires instructions, drives pin levels.
// Assumes the bench raises halt_cmd for one cycle and the core advances only while its clock is enabled.
`timescale 1ns/1ns
`default_nettype none
module sewc_core_model (
  input wire logic clk, // System clock
  input wire logic arst_n, // Reset, active low
  input wire logic halt_cmd, // Bench asks for a halt
  input wire logic core_clk_en, // Core clock gate
  output logic halt_exec, // Halt executes, one cycle
  output logic instr_retired, // One instruction completed
  output logic [7:0] pin_out_core, // Pin levels
  output logic [7:0] pin_oe_core // Pin enables
);
  logic [7:0] cnt;
  // ==========================================
  // Instruction stream
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 8'h00;
      halt_exec <= 1'b0;
      instr_retired <= 1'b0;
    end else if (core_clk_en) begin
      cnt <= cnt + 8'h01;
      halt_exec <= halt_cmd;
      instr_retired <= (cnt[1:0] == 2'h3);
    end else begin
      halt_exec <= 1'b0;
      instr_retired <= 1'b0;
    end
  end
  // ==========================================
  // Pin drive
  // A stopped core gives no meaningful levels, so they wander every cycle to expose a leaky hold
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_out_core <= 8'h00;
      pin_oe_core <= 8'h00;
    end else if (core_clk_en) begin
      pin_out_core <= cnt;
      pin_oe_core <= ~cnt;
    end else begin
      pin_out_core <= ~pin_out_core;
      pin_oe_core <= pin_oe_core + 8'h01;
    end
  end
endmodule : sewc_core_model
`default_nettype wire

// ===== bench/tb_sleep_entry_wake_control.sv
// Self-checking bench of the sleep entry and wake control block.
// Assumes the map header on the include path and the core model compiled beside it.
`include "sewc_map.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_sleep_entry_wake_control;
  import sewc_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  sewc_bus_req_type bus_req = '0;
  sewc_bus_rsp_type bus_rsp;
  logic irq, halt_exec, instr_retired, core_clk_en, prefetch_req, vector_req, device_reset_n;
  logic lf_osc_en, timer2nd_clk_en, adc_clk_en;
  logic master_clear_pin_n = 1'b1;
  logic brownout_det = 1'b0;
  logic watchdog_tick = 1'b0;
  logic halt_cmd = 1'b0;
  logic [2:0] ext_irq_pin = 3'h0;
  logic [7:0] periph_evt_1 = 8'h00, periph_evt_2 = 8'h00, periph_evt_3 = 8'h00, periph_evt_4 = 8'h00;
  logic [7:0] pin_out_core, pin_oe_core, pin_out, pin_oe, watchdog_counter, rd_val, held, held_oe, d;
  int n_fail = 0;
  int n_checks = 0;
  int seed = 32'ha205;
  int n;
  always #5 clk = ~clk;
  sewc_top sewc_top_i (.clk, .arst_n, .bus_req, .bus_rsp, .irq, .halt_exec, .instr_retired,
    .core_clk_en, .prefetch_req, .vector_req, .device_reset_n, .master_clear_pin_n, .brownout_det,
    .watchdog_tick, .ext_irq_pin, .periph_evt_1, .periph_evt_2, .periph_evt_3, .periph_evt_4,
    .lf_osc_en, .timer2nd_clk_en, .adc_clk_en, .pin_out_core, .pin_oe_core, .pin_out, .pin_oe,
    .watchdog_counter);
  sewc_core_model sewc_core_model_i (.clk, .arst_n, .halt_cmd, .core_clk_en, .halt_exec,
    .instr_retired, .pin_out_core, .pin_oe_core);
  // ==========================================
  // Comparison and bus tasks
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp, input string what);
    chk8({7'h00, got}, {7'h00, exp}, what);
  endtask : chk1
  task automatic bus(input logic [5:0] a, input logic wr, input logic [7:0] wd);
    int k;
    @(posedge clk);
    bus_req <= '{address: a, read: !wr, write: wr, writedata: {24'h0, wd}};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (bus_rsp.waitrequest !== 1'b0 && k < 50);
    rd_val = bus_rsp.readdata[7:0];
    bus_req <= '0;
  endtask : bus
  task automatic wait_run(input logic v);
    for (n = 0; n < 40 && core_clk_en !== v; n++) begin
      @(posedge clk);
      #1;
    end
  endtask : wait_run
  task automatic enter_sleep;
    @(posedge clk);
    halt_cmd <= 1'b1;
    @(posedge clk);
    halt_cmd <= 1'b0;
    #1 chk1(prefetch_req, 1'b1, "prefetch at halt");
    @(posedge clk);
    #1 chk1(core_clk_en, 1'b0, "core clock stopped");
    chk8(watchdog_counter, 8'h00, "watchdog at entry");
    held = pin_out;
    held_oe = pin_oe;
  endtask : enter_sleep
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  initial begin
    #200000;
    n_fail++;
    conclude();
  end
  // ==========================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    bus(`SEWC_OFS_PERIPHERAL_IRQ_ENABLE_3, 1'b0, 8'h00);
    chk8(rd_val, `SEWC_PERIPHERAL_IRQ_ENABLE_3_RESET, "enable 3 reset");
    bus(6'h34, 1'b1, 8'hff);
    bus(6'h34, 1'b0, 8'h00);
    chk8(rd_val, 8'h00, "unmapped read");
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      bus(`SEWC_OFS_PERIPHERAL_IRQ_ENABLE_3, 1'b1, d);
      bus(`SEWC_OFS_PERIPHERAL_IRQ_ENABLE_3, 1'b0, 8'h00);
      chk8(rd_val, d & 8'h10, "enable 3 bits");
    end
    $display("test registers done");
    bus(`SEWC_OFS_WAKE_CONFIG, 1'b1, 8'h56);
    bus(`SEWC_OFS_EVT_MASK, 1'b1, 8'h07);
    bus(`SEWC_OFS_PERIPHERAL_IRQ_ENABLE_3, 1'b1, 8'h10);
    bus(`SEWC_OFS_IRQ_CONTROL, 1'b1, 8'h80);
    enter_sleep();
    bus(`SEWC_OFS_CORE_STATUS, 1'b0, 8'h00);
    chk8(rd_val, 8'h10, "status after entry");
    chk1(lf_osc_en, 1'b1, "low freq osc");
    chk1(timer2nd_clk_en, 1'b1, "timer clock");
    chk1(adc_clk_en, 1'b1, "adc clock");
    chk1(irq, 1'b1, "entry interrupt");
    periph_evt_1 <= $random(seed);
    repeat (8) @(posedge clk);
    #1 chk1(core_clk_en, 1'b0, "disabled source stays asleep");
    chk8(pin_out, held, "pin level hold");
    chk8(pin_oe, held_oe, "pin enable hold");
    periph_evt_1 <= 8'h00;
    $display("test entry done");
    periph_evt_3 <= 8'h10;
    wait_run(1'b1);
    chk1(core_clk_en, 1'b1, "peripheral wake");
    chk8(watchdog_counter, 8'h00, "watchdog at wake");
    periph_evt_3 <= 8'h00;
    for (n = 0; n < 20 && vector_req !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk1(vector_req, 1'b1, "vector after wake");
    bus(`SEWC_OFS_EVT_STATUS, 1'b0, 8'h00);
    chk8(rd_val, 8'h03, "event status");
    bus(`SEWC_OFS_EVT_STATUS, 1'b1, 8'h03);
    #1 chk1(irq, 1'b0, "interrupt cleared");
    $display("test peripheral wake done");
    bus(`SEWC_OFS_PERIPHERAL_IRQ_FLAGS_3, 1'b1, 8'h00);
    bus(`SEWC_OFS_EVT_MASK, 1'b1, 8'h00);
    bus(`SEWC_OFS_IRQ_CONTROL, 1'b1, 8'h01);
    enter_sleep();
    chk1(irq, 1'b0, "masked interrupt");
    ext_irq_pin <= 3'h1;
    wait_run(1'b1);
    chk1(core_clk_en, 1'b1, "external wake, global clear");
    d = 8'h00;
    repeat (20) begin
      @(posedge clk);
      #1;
      d = d | {7'h00, vector_req};
    end
    chk8(d, 8'h00, "no vector with global clear");
    ext_irq_pin <= 3'h0;
    $display("test external wake done");
    enter_sleep();
    master_clear_pin_n <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk1(device_reset_n, 1'b0, "master clear resets");
    chk1(core_clk_en, 1'b1, "master clear wakes");
    master_clear_pin_n <= 1'b1;
    repeat (4) @(posedge clk);
    enter_sleep();
    brownout_det <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk1(device_reset_n, 1'b0, "brown-out resets asleep");
    brownout_det <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk1(device_reset_n, 1'b1, "reset released");
    $display("test reset wake done");
    // Watchdog wake, with unqualified timer source and ADC off its own oscillator
    bus(`SEWC_OFS_EVT_STATUS, 1'b1, 8'h07);
    bus(`SEWC_OFS_WAKE_CONFIG, 1'b1, 8'h09);
    enter_sleep();
    chk1(timer2nd_clk_en, 1'b0, "timer clock stopped");
    chk1(adc_clk_en, 1'b0, "adc clock stopped");
    watchdog_tick <= 1'b1;
    for (n = 0; n < 400 && core_clk_en !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk1(core_clk_en, 1'b1, "watchdog wake");
    chk8(watchdog_counter, 8'h00, "watchdog cleared at wake");
    watchdog_tick <= 1'b0;
    bus(`SEWC_OFS_EVT_STATUS, 1'b0, 8'h00);
    chk8(rd_val, 8'h05, "watchdog wake event");
    $display("test watchdog wake done");
    conclude();
  end
endmodule : tb_sleep_entry_wake_control
`default_nettype wire
